// ==== logic/ten_mbps_ops_pkg.sv ====
package ten_mbps_ops_pkg;

   // Register location and width
   localparam logic [4:0]  OPS_ADDR        = 5'h12;
   localparam int          REG_W           = 16;

   // Field positions inside the register
   localparam int          REMOTE_JAB_BIT  = 15;
   localparam int          POL_REV_BIT     = 14;
   localparam int          JAB_INH_BIT     = 5;
   localparam int          RSVD_ONE_BIT    = 4;
   localparam int          AUTO_POL_BIT    = 3;
   localparam int          SQE_INH_BIT     = 2;
   localparam int          LINK_INH_BIT    = 1;
   localparam int          SQUELCH_INH_BIT = 0;

   // Value after reset of the whole register
   localparam logic [15:0] OPS_RESET       = 16'h0010;

   // Clock rate and timing figures
   localparam int          CLK_MHZ         = 250;
   localparam int          JABBER_TIME_US  = 20000;
   localparam int          JABBER_CYCLES   = JABBER_TIME_US * CLK_MHZ;
   localparam int          SQE_TIME_NS     = 1000;
   localparam int          SQE_CYCLES      = (SQE_TIME_NS * CLK_MHZ) / 1000;
   localparam int          CNT_W           = 24;

   // SQE test sequencer states
   typedef enum logic [1:0]
   {
      SQE_IDLE  = 2'b01,
      SQE_PULSE = 2'b10
   } sqe_state_e;

endpackage

// ==== logic/ten_mbps_ops_reg.sv ====
`timescale 1ns/10ps
module ten_mbps_ops_reg
#(
   parameter int JABBER_CYCLES = ten_mbps_ops_pkg::JABBER_CYCLES,
   parameter int SQE_CYCLES    = ten_mbps_ops_pkg::SQE_CYCLES
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        portReset,
   input  wire logic [4:0]  regAddr,
   input  wire logic        regWrEn,
   input  wire logic [15:0] regWrData,
   input  wire logic        regRdEn,
   input  wire logic        rxActive,
   input  wire logic        polarityDetected,
   input  wire logic        txEnable,
   input  wire logic        fullDuplex,
   input  wire logic        repeaterMode,
   output logic [15:0]      regRdData,
   output logic             regRdValid,
   output logic             collisionSqe,
   output logic             txJabber,
   output logic             autoPolarityEnable,
   output logic             linkForcePass,
   output logic             squelchNeedIdle
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks

   // Counters must fit their width and run at least one cycle
   if (JABBER_CYCLES < 1 || JABBER_CYCLES >= (1 << ten_mbps_ops_pkg::CNT_W))
   begin : gJabChk
      $error("JABBER_CYCLES out of range");
   end
   if (SQE_CYCLES < 1 || SQE_CYCLES >= (1 << ten_mbps_ops_pkg::CNT_W))
   begin : gSqeChk
      $error("SQE_CYCLES out of range");
   end

   // Counter fields below are written for a 24-bit width
   if (ten_mbps_ops_pkg::CNT_W != 24)
   begin : gWidthChk
      $error("CNT_W does not match the counter fields");
   end

   // Terminal counts of the jabber timers (receive and transmit share one) and the SQE timer
   localparam logic [23:0] JAB_LIMIT = 24'(JABBER_CYCLES - 1);
   localparam logic [23:0] SQE_LIMIT = 24'(SQE_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed
   {
      // Register fields seen by the host
      logic                          remoteJab;   // Latched receive jabber
      logic                          polRev;      // Live polarity report
      logic                          jabInh;      // Transmit jabber check off
      logic                          autoPolEn;   // Polarity correction on
      logic                          sqeInh;      // SQE test off
      logic                          linkInh;     // Force link passed
      logic                          squelchInh;  // Need data then idle
      // Jabber timers
      logic [23:0]                   rxCnt;       // Receive activity length
      logic [23:0]                   txCnt;       // Transmit activity length
      logic                          txJab;       // Transmit jabber seen
      // SQE test
      logic                          txPrev;      // Transmit enable last cycle
      ten_mbps_ops_pkg::sqe_state_e  sqeState;    // SQE sequencer
      logic [23:0]                   sqeCnt;      // SQE pulse length
      logic                          col;         // Collision pulse out
      // Read port
      logic [15:0]                   rdData;      // Read answer
      logic                          rdValid;     // Read answer strobe
   } state_s;

   state_s state_reg;  // Registered state
   state_s state_next; // Next state

   ////////////////////////////////////////////////////////////////////////////
   // Next state logic

   always_comb
   begin
      // Working values for this cycle
      logic hit;
      logic rdHit;
      logic rxJabEvent;
      logic [15:0] snap;
      hit        = (regAddr == ten_mbps_ops_pkg::OPS_ADDR);
      rdHit      = hit && regRdEn;
      rxJabEvent = 1'b0;
      snap       = 16'h0000;
      // Hold everything unless changed below
      state_next = state_reg;

      // Receive path jabber timer, same limit as transmit but never inhibited by jabInh
      if (rxActive)
      begin
         // Limit reached: flag every cycle while still active
         if (state_reg.rxCnt == JAB_LIMIT)
         begin
            rxJabEvent = 1'b1;
         end
         else
         begin
            // Count one more cycle of activity
            state_next.rxCnt = state_reg.rxCnt + 24'h0001;
         end
      end
      else
      begin
         // Quiet line restarts the timer
         state_next.rxCnt = 24'h0000;
      end

      // Read answer built from current state
      snap[ten_mbps_ops_pkg::REMOTE_JAB_BIT]  = state_reg.remoteJab;
      snap[ten_mbps_ops_pkg::POL_REV_BIT]     = state_reg.polRev;
      snap[ten_mbps_ops_pkg::JAB_INH_BIT]     = state_reg.jabInh;
      // Reserved bit four always reads one
      snap[ten_mbps_ops_pkg::RSVD_ONE_BIT]    = 1'b1;
      snap[ten_mbps_ops_pkg::AUTO_POL_BIT]    = !state_reg.autoPolEn;
      snap[ten_mbps_ops_pkg::SQE_INH_BIT]     = state_reg.sqeInh;
      snap[ten_mbps_ops_pkg::LINK_INH_BIT]    = state_reg.linkInh;
      snap[ten_mbps_ops_pkg::SQUELCH_INH_BIT] = state_reg.squelchInh;
      // Only a read of this address answers
      state_next.rdValid = rdHit;
      if (rdHit)
      begin
         state_next.rdData = snap;
      end

      // Remote jabber latch: set wins over read clear
      if (portReset)
      begin
         // Port reset beats everything
         state_next.remoteJab = 1'b0;
      end
      else if (rxJabEvent)
      begin
         // New event survives a read in the same cycle
         state_next.remoteJab = 1'b1;
      end
      else if (rdHit)
      begin
         // Cleared once the answer has captured it
         state_next.remoteJab = 1'b0;
      end

      // Polarity status follows the detector
      state_next.polRev = polarityDetected;

      // Control writes; reserved bits are ignored
      if (portReset)
      begin
         // Port reset restores the defaults
         state_next.jabInh     = OPS_RESET_BIT(ten_mbps_ops_pkg::JAB_INH_BIT);
         state_next.autoPolEn  = !OPS_RESET_BIT(ten_mbps_ops_pkg::AUTO_POL_BIT);
         state_next.sqeInh     = OPS_RESET_BIT(ten_mbps_ops_pkg::SQE_INH_BIT);
         state_next.linkInh    = OPS_RESET_BIT(ten_mbps_ops_pkg::LINK_INH_BIT);
         state_next.squelchInh = OPS_RESET_BIT(ten_mbps_ops_pkg::SQUELCH_INH_BIT);
      end
      else if (hit && regWrEn)
      begin
         // Only the five control bits are stored
         state_next.jabInh     = regWrData[ten_mbps_ops_pkg::JAB_INH_BIT];
         state_next.autoPolEn  = !regWrData[ten_mbps_ops_pkg::AUTO_POL_BIT];
         state_next.sqeInh     = regWrData[ten_mbps_ops_pkg::SQE_INH_BIT];
         state_next.linkInh    = regWrData[ten_mbps_ops_pkg::LINK_INH_BIT];
         state_next.squelchInh = regWrData[ten_mbps_ops_pkg::SQUELCH_INH_BIT];
      end

      // Transmit jabber check, skipped when inhibited
      if (!txEnable || state_reg.jabInh)
      begin
         // Idle or inhibited: timer and flag cleared
         state_next.txCnt = 24'h0000;
         state_next.txJab = 1'b0;
      end
      else if (state_reg.txCnt == JAB_LIMIT)
      begin
         // Transmission ran too long
         state_next.txJab = 1'b1;
      end
      else
      begin
         // Count one more cycle of transmission
         state_next.txCnt = state_reg.txCnt + 24'h0001;
      end

      // SQE test sequencer
      state_next.txPrev = txEnable;
      case (state_reg.sqeState)
         ten_mbps_ops_pkg::SQE_IDLE:
         begin
            state_next.col = 1'b0;
            // Falling transmit enable starts the test
            if (state_reg.txPrev && !txEnable && !state_reg.sqeInh
                && !fullDuplex && !repeaterMode)
            begin
               state_next.sqeState = ten_mbps_ops_pkg::SQE_PULSE;
               state_next.sqeCnt   = 24'h0000;
               state_next.col      = 1'b1;
            end
         end
         ten_mbps_ops_pkg::SQE_PULSE:
         begin
            // Hold collision for the test length
            if (state_reg.sqeCnt == SQE_LIMIT)
            begin
               state_next.sqeState = ten_mbps_ops_pkg::SQE_IDLE;
               state_next.col      = 1'b0;
            end
            else
            begin
               // Pulse still running
               state_next.sqeCnt = state_reg.sqeCnt + 24'h0001;
            end
         end
         default:
         begin
            // Illegal code falls back to idle
            state_next.sqeState = ten_mbps_ops_pkg::SQE_IDLE;
            state_next.col      = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset value helper

   // Picks one bit of the register reset value
   function automatic logic OPS_RESET_BIT(input int pos);
      return ten_mbps_ops_pkg::OPS_RESET[pos];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // Asynchronous reset loads the idle state
         state_reg <= '{
            remoteJab:  1'b0,
            polRev:     1'b0,
            jabInh:     1'b0,
            autoPolEn:  1'b1,
            sqeInh:     1'b0,
            linkInh:    1'b0,
            squelchInh: 1'b0,
            rxCnt:      24'h0000,
            txCnt:      24'h0000,
            txJab:      1'b0,
            txPrev:     1'b0,
            sqeState:   ten_mbps_ops_pkg::SQE_IDLE,
            sqeCnt:     24'h0000,
            col:        1'b0,
            rdData:     16'h0000,
            rdValid:    1'b0
         };
      end
      else
      begin
         // Load the next state
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all from flops

   // Read port answer
   assign regRdData          = state_reg.rdData;
   assign regRdValid         = state_reg.rdValid;

   // Transmit side: SQE pulse and jabber
   assign collisionSqe       = state_reg.col;
   assign txJabber           = state_reg.txJab;

   // Receive and link controls; polarity swap never gates any function
   assign autoPolarityEnable = state_reg.autoPolEn;
   assign linkForcePass      = state_reg.linkInh;
   assign squelchNeedIdle    = state_reg.squelchInh;

endmodule

// ==== testbench/ten_mbps_ops_assertions.sv ====
`timescale 1ns/10ps
module ten_mbps_ops_assertions
#(
   parameter int SQE_CYCLES = 4
)
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        portReset,
   input wire logic [4:0]  regAddr,
   input wire logic        regWrEn,
   input wire logic [15:0] regWrData,
   input wire logic        regRdEn,
   input wire logic        polarityDetected,
   input wire logic        txEnable,
   input wire logic        fullDuplex,
   input wire logic        repeaterMode,
   input wire logic [15:0] regRdData,
   input wire logic        regRdValid,
   input wire logic        collisionSqe,
   input wire logic        txJabber,
   input wire logic        autoPolarityEnable,
   input wire logic        linkForcePass,
   input wire logic        squelchNeedIdle
);
   ////////////////////////////////////////////////////////////////
   logic [7:0] sqeLen_reg; // Length of the running SQE pulse

   // Counts cycles of the collision pulse
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         sqeLen_reg <= 8'h00;
      else
         sqeLen_reg <= collisionSqe ? sqeLen_reg + 8'h01 : 8'h00;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence wrOp;
      regWrEn && regAddr == 5'h12 && !portReset;
   endsequence
   sequence txEnd;
      $fell(txEnable);
   endsequence

   AST_RD_ANSWER: assert property (regRdEn && regAddr == 5'h12 |=> regRdValid)
      else $error("read not answered");
   AST_RSVD: assert property (regRdValid |-> regRdData[13:6] == 8'h00 && regRdData[4])
      else $error("reserved bits wrong");
   AST_POL: assert property ($past(polarityDetected) == $past(polarityDetected, 2)
      && $past(polarityDetected, 2) == $past(polarityDetected, 3) && regRdValid
      |-> regRdData[14] == $past(polarityDetected, 2)) else $error("polarity flag wrong");
   AST_APOL: assert property (wrOp |=> autoPolarityEnable == !$past(regWrData[3]))
      else $error("auto polarity enable wrong");
   AST_LINK: assert property (wrOp |=> linkForcePass == $past(regWrData[1]))
      else $error("link force wrong");
   AST_SQUELCH: assert property (wrOp |=> squelchNeedIdle == $past(regWrData[0]))
      else $error("squelch control wrong");
   AST_SQE_MODE: assert property (txEnd ##0 (fullDuplex || repeaterMode) |=> !collisionSqe [*4])
      else $error("SQE in suppressed mode");
   AST_SQE_CAUSE: assert property ($rose(collisionSqe) |-> $past(txEnable, 2) && !$past(txEnable))
      else $error("SQE without transmit end");
   AST_SQE_LEN: assert property (!collisionSqe && sqeLen_reg != 8'h00 |-> sqeLen_reg == 8'(SQE_CYCLES))
      else $error("SQE length wrong");
   AST_TXJAB: assert property (!txEnable |=> !txJabber)
      else $error("jabber without transmit");
endmodule

bind ten_mbps_ops_reg ten_mbps_ops_assertions #(.SQE_CYCLES(SQE_CYCLES)) ten_mbps_ops_assertions_i (.*);

// ==== testbench/mgmt_entity.sv ====
`timescale 1ns/10ps
module mgmt_entity
(
   input  wire logic        clk,
   output logic [4:0]       regAddr,
   output logic             regWrEn,
   output logic [15:0]      regWrData,
   output logic             regRdEn,
   input  wire logic [15:0] regRdData
);
   // Idle bus at time zero
   initial
   begin
      regAddr = 5'h00;
      regWrEn = 1'b0;
      regWrData = 16'h0000;
      regRdEn = 1'b0;
   end

   // One write, reserved bits forced to defaults
   task wr(input logic [15:0] d);
      @(posedge clk);
      regAddr <= 5'h12;
      regWrEn <= 1'b1;
      regWrData <= (d & 16'hc02f) | 16'h0010;
      @(posedge clk);
      regWrEn <= 1'b0;
      regAddr <= 5'h00;
      regWrData <= ~regWrData;
      #1;
   endtask

   // One read, data taken in the answer cycle
   task rd(output logic [15:0] d);
      @(posedge clk);
      regAddr <= 5'h12;
      regRdEn <= 1'b1;
      @(posedge clk);
      regRdEn <= 1'b0;
      regAddr <= 5'h00;
      #1;
      d = regRdData;
   endtask
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/10ps
module tb;
   logic        clk, rst_n, portReset, rxActive, polarityDetected, txEnable;
   logic        fullDuplex, repeaterMode, regWrEn, regRdEn, regRdValid, collisionSqe;
   logic        txJabber, autoPolarityEnable, linkForcePass, squelchNeedIdle, j;
   logic [4:0]  regAddr;
   logic [15:0] regWrData, regRdData, d, n;
   int          failures, n_compared;

   ten_mbps_ops_reg #(.JABBER_CYCLES(16), .SQE_CYCLES(4)) ten_mbps_ops_reg_i (.*);
   mgmt_entity mgmt_entity_i (.*);

   ////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      n_compared++;
      if (s !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   // Transmit burst, then count collision cycles
   task automatic burst(input int len, output logic [15:0] cnt, output logic jab);
      cnt = 16'h0000;
      @(posedge clk) txEnable <= 1'b1;
      cyc(len);
      #1 jab = txJabber;
      @(posedge clk) txEnable <= 1'b0;
      repeat (10)
      begin
         @(posedge clk);
         #1 cnt = cnt + 16'(collisionSqe);
      end
   endtask

   task automatic test_ctrl;
      mgmt_entity_i.wr(16'hffff);
      chk("apol", 16'(autoPolarityEnable), 16'h0000);
      chk("link", 16'(linkForcePass), 16'h0001);
      chk("squelch", 16'(squelchNeedIdle), 16'h0001);
      mgmt_entity_i.rd(d);
      chk("ctrl", d, 16'h003f);
      burst(20, n, j);
      chk("txjab inh", 16'(j), 16'h0000);
      chk("sqe inh", n, 16'h0000);
      mgmt_entity_i.rd(d);
      chk("sqe bit", 16'(d[2]), 16'h0001);
      mgmt_entity_i.wr(16'h0000);
      chk("apol back", 16'(autoPolarityEnable), 16'h0001);
   endtask

   task automatic test_sqe;
      burst(20, n, j);
      chk("sqe", n, 16'h0004);
      chk("txjab", 16'(j), 16'h0001);
      @(posedge clk) fullDuplex <= 1'b1;
      burst(3, n, j);
      chk("sqe fdx", n, 16'h0000);
      mgmt_entity_i.rd(d);
      chk("sqe bit fdx", 16'(d[2]), 16'h0000);
      @(posedge clk) {fullDuplex, repeaterMode} <= 2'b01;
      burst(3, n, j);
      chk("sqe rep", n, 16'h0000);
      @(posedge clk) repeaterMode <= 1'b0;
   endtask

   task automatic test_rxjab;
      @(posedge clk) rxActive <= 1'b1;
      cyc(10);
      mgmt_entity_i.rd(d);
      chk("rjab early", d, 16'h0010);
      cyc(10);
      mgmt_entity_i.rd(d);
      chk("rjab set", d, 16'h8010);
      mgmt_entity_i.rd(d);
      chk("rjab held", d, 16'h8010);
      @(posedge clk) rxActive <= 1'b0;
      mgmt_entity_i.rd(d);
      chk("rjab last", d, 16'h8010);
      mgmt_entity_i.rd(d);
      chk("rjab clr", d, 16'h0010);
      @(posedge clk) rxActive <= 1'b1;
      cyc(20);
      rxActive <= 1'b0;
      portReset <= 1'b1;
      @(posedge clk) portReset <= 1'b0;
      mgmt_entity_i.rd(d);
      chk("rjab port", d, 16'h0010);
   endtask

   task automatic test_pol;
      @(posedge clk) polarityDetected <= 1'b1;
      cyc(3);
      mgmt_entity_i.rd(d);
      chk("pol", d, 16'h4010);
      chk("pol apol", 16'(autoPolarityEnable), 16'h0001);
      @(posedge clk) polarityDetected <= 1'b0;
   endtask

   task automatic finish_test;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Watchdog against a hang
   initial
   begin
      cyc(3000);
      failures++;
      finish_test;
   end

   initial
   begin
      {rst_n, portReset, rxActive, polarityDetected} = 4'h0;
      {txEnable, fullDuplex, repeaterMode} = 3'h0;
      failures = 0;
      n_compared = 0;
      cyc(3);
      rst_n <= 1'b1;
      mgmt_entity_i.rd(d);
      chk("reset", d, 16'h0010);
      chk("valid", 16'(regRdValid), 16'h0001);
      test_ctrl;
      test_sqe;
      test_rxjab;
      test_pol;
      finish_test;
   end
endmodule
